// *** hwm_seq.sv ***
// sequencer, readings, limits and sticky status of the hardware monitor
// assumes the serial bus engine hands in byte strobes and the converter
// returns a code on conv_data_in by the end of each conversion period
`timescale 1ns/1ps
`include "hwm_defs.svh"
module hwm_seq
  import hwm_pkg::*;
#(
  parameter int unsigned IDLE_TICKS = `HWM_IDLE_TICKS,
  parameter int unsigned TICK_DIV = `HWM_TICK_DIV
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // register port from the serial bus engine
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // converter
  output logic conv_start_out,
  output logic [2:0] conv_chan_out,
  input wire logic [7:0] conv_data_in,
  // remote diode pin conditions
  input wire logic [1:0] diode_fault_in,
  input wire logic [1:0] diode_neg_gnd_in,
  // outputs to the system
  output logic irq_n_out,
  output logic [1:0] fan_full_out,
  output logic busy_out
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  hwm_state_t state_ff;
  logic [2:0] chan_ff;
  logic [6:0] period_ff;
  logic [16:0] idle_ff;
  logic start_ff;
  logic lock_ff;
  logic [7:0] sfr_ff;
  logic [6:0] conf_ff;
  logic soft_rst_ff;
  logic [7:0] en1_ff;
  logic [7:0] grp_ff;
  logic [7:0] status1_ff;
  logic [1:0] status2_ff;
  logic [7:0] active_ff;
  logic [7:0] reading_ff [0:7];
  logic [7:0] lim_lo_ff [0:7];
  logic [7:0] lim_hi_ff [0:7];
  logic [7:0] res_ff;
  logic [7:0] nxt_reading;
  logic [7:0] nxt_set1;
  logic [1:0] nxt_set2;
  logic any_rst;
  logic tick;
  logic sample;
  logic avg_done;
  logic [7:0] avg_result;
  logic [2:0] shift;
  logic is_temp;
  logic is_diode;
  logic dsel;
  logic [6:0] last_tick;
  logic cycle_mode;
  logic err;
  logic rd_st1;
  logic rd_st2;

  assign any_rst = srst_in || soft_rst_ff;
  assign cycle_mode = sfr_ff[`HWM_MODE_BIT];
  assign is_diode = chan_ff == `HWM_CH_D1 || chan_ff == `HWM_CH_D2;
  assign is_temp = is_diode || chan_ff == `HWM_CH_AMB;
  assign dsel = chan_ff == `HWM_CH_D2;
  assign last_tick = is_temp ? `HWM_TEMP_TICKS - 7'd1 : `HWM_VOLT_TICKS - 7'd1;
  assign sample = state_ff == ST_CONV && tick && period_ff == last_tick;
  assign rd_st1 = reg_rd_in && reg_addr_in == `HWM_STATUS1;
  assign rd_st2 = reg_rd_in && reg_addr_in == `HWM_STATUS2;

  // averaging depth as a shift, top select bit wins
  always_comb begin
    unique casez (sfr_ff[`HWM_AVG_MSB:`HWM_AVG_LSB])
      3'b1??: shift = 3'd5;
      3'b01?: shift = 3'd4;
      3'b001: shift = is_diode ? 3'd4 : 3'd0;
      3'b000: shift = is_diode ? 3'd7 : 3'd3;
    endcase
  end

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  hwm_tick #(.DIV(TICK_DIV)) u_tick (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .tick_out(tick)
  );

  hwm_avg u_avg (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .clr_in(state_ff == ST_STORE || state_ff == ST_IDLE),
    .sample_in(sample),
    .shift_in(shift),
    .data_in(conv_data_in),
    .done_out(avg_done),
    .result_out(avg_result)
  );

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      start_ff <= 1'b0;
      lock_ff <= 1'b0;
      sfr_ff <= `HWM_SFR_RST;
      en1_ff <= `HWM_EN1_RST;
      grp_ff <= `HWM_GRP_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `HWM_RLS) begin
        // lock holds start until the next reset
        if (!lock_ff) begin
          start_ff <= reg_wdata_in[`HWM_START_BIT];
        end
        lock_ff <= lock_ff || reg_wdata_in[`HWM_LOCK_BIT];
      end
      if (reg_addr_in == `HWM_SFR) begin
        sfr_ff[7:1] <= reg_wdata_in[7:1];
        if (!lock_ff) begin
          sfr_ff[`HWM_LPMD_BIT] <= reg_wdata_in[`HWM_LPMD_BIT];
        end
      end
      if (reg_addr_in == `HWM_EN1) begin
        en1_ff <= reg_wdata_in;
      end
      if (reg_addr_in == `HWM_GRP_EN) begin
        grp_ff <= reg_wdata_in;
      end
    end
  end

  // soft reset pulse is self clearing; it clears config too
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      soft_rst_ff <= 1'b0;
      conf_ff <= 7'h00;
    end else if (reg_wr_in && reg_addr_in == `HWM_CONF) begin
      soft_rst_ff <= reg_wdata_in[`HWM_SRST_BIT];
      conf_ff <= reg_wdata_in[6:0];
    end
  end

  // limits: reset on power on and soft reset
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_lim
      always_ff @(posedge clk_in) begin
        if (any_rst) begin
          lim_lo_ff[gi] <= `HWM_LIM_LO_RST;
          lim_hi_ff[gi] <= `HWM_LIM_HI_RST;
        end else if (reg_wr_in) begin
          if (reg_addr_in == `HWM_LIM_LO_BASE + 8'(gi)) begin
            lim_lo_ff[gi] <= reg_wdata_in;
          end
          if (reg_addr_in == `HWM_LIM_HI_BASE + 8'(gi)) begin
            lim_hi_ff[gi] <= reg_wdata_in;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      state_ff <= ST_IDLE;
      chan_ff <= `HWM_CH_D1;
      period_ff <= 7'd0;
      idle_ff <= 17'd0;
      res_ff <= 8'h00;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          chan_ff <= `HWM_CH_D1;
          if (start_ff) begin
            state_ff <= ST_LAUNCH;
          end
        end
        ST_LAUNCH: begin
          period_ff <= 7'd0;
          state_ff <= ST_CONV;
        end
        ST_CONV: begin
          if (tick) begin
            period_ff <= period_ff + 7'd1;
          end
          if (avg_done) begin
            res_ff <= avg_result;
            state_ff <= ST_STORE;
          end else if (sample) begin
            state_ff <= ST_LAUNCH;
          end
        end
        ST_STORE: begin
          if (!start_ff) begin
            state_ff <= ST_IDLE;
          end else if (chan_ff != `HWM_CH_LAST) begin
            chan_ff <= chan_ff + 3'd1;
            state_ff <= ST_LAUNCH;
          end else if (cycle_mode) begin
            idle_ff <= 17'd0;
            state_ff <= ST_PAUSE;
          end else begin
            chan_ff <= `HWM_CH_D1;
            state_ff <= ST_LAUNCH;
          end
        end
        ST_PAUSE: begin
          // idle counted in conversion ticks to keep the counter short
          if (!start_ff) begin
            state_ff <= ST_IDLE;
          end else if (tick) begin
            idle_ff <= idle_ff + 17'd1;
            if (idle_ff == 17'(IDLE_TICKS - 1)) begin
              chan_ff <= `HWM_CH_D1;
              state_ff <= ST_LAUNCH;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // readings and limit check
  // ----------------------------------------
  always_comb begin
    nxt_reading = res_ff;
    if (is_diode && diode_fault_in[dsel]) begin
      if (!en1_ff[chan_ff]) begin
        nxt_reading = `HWM_FORCE_OFF;
      end else if (!diode_neg_gnd_in[dsel]) begin
        nxt_reading = `HWM_FORCE_FAULT;
      end
    end
  end

  // equal to a limit counts as a violation
  assign err = nxt_reading >= lim_hi_ff[chan_ff] || nxt_reading <= lim_lo_ff[chan_ff];

  // readings survive soft reset; only stored once per pass
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < 8; i++) begin
        reading_ff[i] <= 8'h00;
      end
    end else if (state_ff == ST_STORE) begin
      reading_ff[chan_ff] <= nxt_reading;
    end
  end

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      active_ff <= 8'h00;
    end else if (state_ff == ST_STORE) begin
      active_ff[chan_ff] <= err;
    end
  end

  // ----------------------------------------
  // sticky status
  // ----------------------------------------
  always_comb begin
    nxt_set1 = 8'h00;
    nxt_set2 = 2'b00;
    if (state_ff == ST_STORE) begin
      nxt_set1[chan_ff] = err && en1_ff[chan_ff];
      if (is_diode) begin
        nxt_set2[dsel] = diode_fault_in[dsel] && en1_ff[chan_ff];
      end
    end
  end

  // set beats the read clear; writes never reach these
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      status1_ff <= 8'h00;
    end else if (rd_st1) begin
      status1_ff <= nxt_set1 | (status1_ff & active_ff);
    end else begin
      status1_ff <= status1_ff | nxt_set1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      status2_ff <= 2'b00;
    end else if (rd_st2) begin
      status2_ff <= nxt_set2 | (status2_ff & diode_fault_in);
    end else begin
      status2_ff <= status2_ff | nxt_set2;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // fault bits stay out of the interrupt; only the forced reading reaches it
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      irq_n_out <= 1'b1;
    end else begin
      irq_n_out <= !(start_ff && sfr_ff[`HWM_IRQ_GLOBAL_ENABLE_BIT] &&
        (((|(status1_ff & en1_ff & `HWM_TEMP_MASK)) && grp_ff[`HWM_GRP_TEMP_BIT]) ||
        ((|(status1_ff & en1_ff & `HWM_VOLT_MASK)) && grp_ff[`HWM_GRP_VOLT_BIT])));
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fan_full_out <= 2'b00;
    end else begin
      fan_full_out[0] <= reading_ff[`HWM_CH_D1] == `HWM_FORCE_FAULT;
      fan_full_out[1] <= reading_ff[`HWM_CH_D2] == `HWM_FORCE_FAULT;
    end
  end

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      conv_start_out <= 1'b0;
      conv_chan_out <= 3'd0;
      busy_out <= 1'b0;
    end else begin
      conv_start_out <= state_ff == ST_LAUNCH;
      conv_chan_out <= chan_ff;
      busy_out <= state_ff != ST_IDLE && state_ff != ST_PAUSE;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= 8'h00;
      if (reg_addr_in[7:3] == `HWM_READ_BASE >> 3) begin
        reg_rdata_out <= reading_ff[reg_addr_in[2:0]];
      end
      for (int i = 0; i < 8; i++) begin
        if (reg_addr_in == `HWM_LIM_LO_BASE + 8'(i)) begin
          reg_rdata_out <= lim_lo_ff[i];
        end
        if (reg_addr_in == `HWM_LIM_HI_BASE + 8'(i)) begin
          reg_rdata_out <= lim_hi_ff[i];
        end
      end
      unique case (reg_addr_in)
        `HWM_RLS: reg_rdata_out <= {6'h00, lock_ff, start_ff};
        `HWM_STATUS1: reg_rdata_out <= status1_ff;
        `HWM_STATUS2: reg_rdata_out <= {6'h00, status2_ff};
        `HWM_EN1: reg_rdata_out <= en1_ff;
        `HWM_GRP_EN: reg_rdata_out <= grp_ff;
        `HWM_SFR: reg_rdata_out <= sfr_ff;
        `HWM_CONF: reg_rdata_out <= {1'b0, conf_ff};
        default: begin
        end
      endcase
    end
  end
endmodule

// *** hwm_defs.svh ***
// constants of the hardware monitor sequencer: offsets, fields, resets, timing
// assumes a 50 MHz system clock and a 45 kHz conversion tick derived from it
`ifndef HWM_DEFS_SVH
`define HWM_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define HWM_CLK_HZ 50000000
`define HWM_CONV_HZ 45000
`define HWM_TICK_DIV (`HWM_CLK_HZ / `HWM_CONV_HZ)
`define HWM_TEMP_TICKS 7'd96
`define HWM_VOLT_TICKS 7'd68
`define HWM_IDLE_MS 1000
`define HWM_IDLE_TICKS (`HWM_IDLE_MS * `HWM_CONV_HZ / 1000)

// ----------------------------------------
// register offsets
// ----------------------------------------
`define HWM_READ_BASE 8'h20
`define HWM_RLS 8'h40
`define HWM_STATUS1 8'h41
`define HWM_STATUS2 8'h42
`define HWM_LIM_LO_BASE 8'h44
`define HWM_LIM_HI_BASE 8'h4c
`define HWM_EN1 8'h70
`define HWM_GRP_EN 8'h71
`define HWM_SFR 8'h7c
`define HWM_CONF 8'h7f

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define HWM_START_BIT 0
`define HWM_LOCK_BIT 1
`define HWM_LPMD_BIT 0
`define HWM_MODE_BIT 1
`define HWM_IRQ_GLOBAL_ENABLE_BIT 2
`define HWM_SRST_BIT 7
`define HWM_AVG_MSB 7
`define HWM_AVG_LSB 5
`define HWM_GRP_TEMP_BIT 0
`define HWM_GRP_VOLT_BIT 1
`define HWM_SFR_RST 8'h40
`define HWM_EN1_RST 8'hff
`define HWM_GRP_RST 8'h00
`define HWM_LIM_LO_RST 8'h00
`define HWM_LIM_HI_RST 8'hff
`define HWM_FORCE_FAULT 8'h80
`define HWM_FORCE_OFF 8'h00
`define HWM_TEMP_MASK 8'h83
`define HWM_VOLT_MASK 8'h7c

// ----------------------------------------
// sequence positions
// ----------------------------------------
`define HWM_CH_D1 3'd0
`define HWM_CH_AMB 3'd1
`define HWM_CH_D2 3'd7
`define HWM_CH_LAST 3'd7

`endif

// *** hwm_pkg.sv ***
// types of the hardware monitor sequencer
// assumes hwm_defs.svh carries every number
package hwm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LAUNCH = 3'b001,
    ST_CONV = 3'b010,
    ST_STORE = 3'b011,
    ST_PAUSE = 3'b100
  } hwm_state_t;
endpackage

// *** hwm_tick.sv ***
// conversion clock tick generator
// assumes a free running system clock; one pulse every DIV clocks
`timescale 1ns/1ps
`include "hwm_defs.svh"
module hwm_tick #(
  parameter int unsigned DIV = `HWM_TICK_DIV
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // tick
  output logic tick_out
);
  logic [15:0] cnt_ff;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in || cnt_ff == 16'(DIV - 1)) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    tick_out <= !srst_in && cnt_ff == 16'(DIV - 1);
  end
endmodule

// *** hwm_avg.sv ***
// averaging accumulator for one reading
// assumes the sample count is a power of two given as a shift
`timescale 1ns/1ps
module hwm_avg (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // control
  input wire logic clr_in,
  input wire logic sample_in,
  input wire logic [2:0] shift_in,
  input wire logic [7:0] data_in,
  // result
  output logic done_out,
  output logic [7:0] result_out
);
  logic [14:0] sum_ff;
  logic [6:0] n_ff;
  logic [14:0] total;
  logic [6:0] last;

  // ----------------------------------------
  // accumulate
  // ----------------------------------------
  // sum plus the sample being taken, so the last one counts
  assign total = sum_ff + {7'h00, data_in};
  assign last = 7'((8'h01 << shift_in) - 8'h01);
  assign done_out = sample_in && n_ff == last;
  assign result_out = 8'(total >> shift_in);

  always_ff @(posedge clk_in) begin
    if (srst_in || clr_in) begin
      sum_ff <= 15'h0000;
      n_ff <= 7'h00;
    end else if (sample_in) begin
      sum_ff <= total;
      n_ff <= n_ff + 7'h01;
    end
  end
endmodule

// *** hwm_seq_chk.sv ***
// port assertions of the monitor sequencer
// assumes one clock domain with synchronous active high reset
`timescale 1ns/1ps
`include "hwm_defs.svh"
module hwm_seq_chk #(
  parameter int unsigned IDLE_TICKS = `HWM_IDLE_TICKS,
  parameter int unsigned TICK_DIV = `HWM_TICK_DIV
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // converter and diode pins
  input wire logic conv_start_out,
  input wire logic [2:0] conv_chan_out,
  input wire logic [7:0] conv_data_in,
  input wire logic [1:0] diode_fault_in,
  input wire logic [1:0] diode_neg_gnd_in,
  // system outputs
  input wire logic irq_n_out,
  input wire logic [1:0] fan_full_out,
  input wire logic busy_out
);
  // ----------------------------------------
  // shadow state
  // ----------------------------------------
  localparam int unsigned DIV = TICK_DIV;
  logic start_ff, lock_ff, irq_global_enable_ff, cycle_ff, busy_d_ff, pause_ff, gap_seen_ff;
  logic [31:0] gap_cnt_ff, low_cnt_ff;
  logic wr_rls, wr_soft;
  assign wr_rls = reg_wr_in && reg_addr_in == `HWM_RLS;
  assign wr_soft = reg_wr_in && reg_addr_in == `HWM_CONF && reg_wdata_in[`HWM_SRST_BIT];
  // start drops a cycle early on soft reset: pause checks go vacuous, start_gate_a can fail falsely
  always_ff @(posedge clk_in) begin
    if (srst_in || wr_soft) begin
      start_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else if (wr_rls && !lock_ff) begin
      start_ff <= reg_wdata_in[`HWM_START_BIT];
      lock_ff <= reg_wdata_in[`HWM_LOCK_BIT];
    end
  end
  // soft reset not mirrored here so the enable check can never fire falsely
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_global_enable_ff <= 1'b0;
      cycle_ff <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `HWM_SFR) begin
      irq_global_enable_ff <= reg_wdata_in[`HWM_IRQ_GLOBAL_ENABLE_BIT];
      cycle_ff <= reg_wdata_in[`HWM_MODE_BIT];
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      gap_cnt_ff <= 32'h0;
      low_cnt_ff <= 32'h0;
      busy_d_ff <= 1'b0;
      pause_ff <= 1'b0;
      gap_seen_ff <= 1'b0;
    end else begin
      gap_cnt_ff <= conv_start_out ? 32'h0 : gap_cnt_ff + 32'h1;
      low_cnt_ff <= busy_out ? 32'h0 : low_cnt_ff + 32'h1;
      busy_d_ff <= busy_out;
      gap_seen_ff <= gap_seen_ff | conv_start_out;
      if (busy_out || !start_ff) begin
        pause_ff <= 1'b0;
      end else if (busy_d_ff) begin
        pause_ff <= cycle_ff;
      end
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence unmapped_rd_s;
    reg_rd_in && reg_addr_in[7];
  endsequence
  sequence pause_end_s;
    $rose(busy_out) && pause_ff;
  endsequence
  reset_quiet_a: assert property (
    $fell(srst_in) |-> irq_n_out && !busy_out && fan_full_out == 2'b00 && reg_rdata_out == 8'h00)
    else $error("outputs not quiet after reset");
  read_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  unmapped_rd_a: assert property (unmapped_rd_s |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  start_gate_a: assert property ($rose(busy_out) |-> start_ff)
    else $error("conversion began without start");
  chan_step_a: assert property (
    $changed(conv_chan_out) |-> conv_chan_out == $past(conv_chan_out) + 3'd1 || conv_chan_out == 3'd0)
    else $error("channel skipped");
  conv_gap_a: assert property (conv_start_out && gap_seen_ff |-> gap_cnt_ff >= 67 * DIV)
    else $error("conversion shorter than its tick count");
  fan_zone_a: assert property ($rose(fan_full_out[0]) |-> $past(conv_chan_out, 3) == 3'd0)
    else $error("zone one forced outside its diode store");
  irq_global_a: assert property (!irq_n_out |-> $past(irq_global_enable_ff))
    else $error("interrupt low with global enable clear");
  pause_end_a: assert property (
    $fell(busy_out) && start_ff |-> cycle_ff && conv_chan_out == `HWM_CH_LAST)
    else $error("sequencer paused outside cycle end");
  pause_len_a: assert property (
    pause_end_s |-> low_cnt_ff >= (IDLE_TICKS - 1) * DIV && low_cnt_ff <= (IDLE_TICKS + 1) * DIV + 8)
    else $error("cycle pause length wrong");
endmodule
bind hwm_seq hwm_seq_chk #(.IDLE_TICKS(IDLE_TICKS), .TICK_DIV(TICK_DIV)) u_hwm_seq_chk (
  .clk_in(clk_in),
  .srst_in(srst_in),
  .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .conv_start_out(conv_start_out),
  .conv_chan_out(conv_chan_out),
  .conv_data_in(conv_data_in),
  .diode_fault_in(diode_fault_in),
  .diode_neg_gnd_in(diode_neg_gnd_in),
  .irq_n_out(irq_n_out),
  .fan_full_out(fan_full_out),
  .busy_out(busy_out)
);

// *** hwm_conv_model.sv ***
// converter and sensed inputs: each launch gets the code of its input
// assumes busy_in stays high for the whole of every conversion
`timescale 1ns/1ps
module hwm_conv_model (
  // clock
  input wire logic clk_in,
  // launch from the sequencer
  input wire logic conv_start_in,
  input wire logic [2:0] conv_chan_in,
  input wire logic busy_in,
  // codes per input
  input wire logic [63:0] chan_vals_in,
  // code to the sequencer
  output logic [7:0] conv_data_out
);
  initial conv_data_out = 8'h5a;
  // code held for the full conversion; while idle it wanders so no stale code looks valid
  always @(posedge clk_in) begin
    if (conv_start_in) begin
      conv_data_out <= chan_vals_in[conv_chan_in * 8 +: 8];
    end else if (!busy_in) begin
      conv_data_out <= ~conv_data_out;
    end
  end
endmodule

// *** test_hw_monitor_sequencer_status.sv ***
// bench of the monitor sequencer: one cycle-mode pass with forced diode faults
// assumes the converter model on the far side; tick divider shortened to 4 clocks
`timescale 1ns/1ps
`include "hwm_defs.svh"
module test_hw_monitor_sequencer_status;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out, conv_data_in, en1;
  logic conv_start_out, irq_n_out, busy_out;
  logic [2:0] conv_chan_out;
  localparam int DIV = 4;
  logic [1:0] diode_fault_in = 2'b00;
  logic [1:0] neg_gnd = 2'b00;
  logic [1:0] fan_full_out;
  logic [63:0] chan_vals = 64'h0;
  logic [7:0] lo [8];
  logic [7:0] hi [8];
  logic [2:0] starts [$];
  int num_errors = 0;
  int total_checks = 0;
  int low_cnt = 0;
  int pause_len = 0;
  integer seed = 36;
  always #10 clk_in = ~clk_in;
  hwm_seq #(.IDLE_TICKS(4), .TICK_DIV(DIV)) u_hwm_seq (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .conv_start_out(conv_start_out), .conv_chan_out(conv_chan_out), .conv_data_in(conv_data_in),
    .diode_fault_in(diode_fault_in), .diode_neg_gnd_in(neg_gnd), .irq_n_out(irq_n_out),
    .fan_full_out(fan_full_out), .busy_out(busy_out));
  hwm_conv_model u_hwm_conv_model (.clk_in(clk_in), .conv_start_in(conv_start_out),
    .conv_chan_in(conv_chan_out), .busy_in(busy_out), .chan_vals_in(chan_vals), .conv_data_out(conv_data_in));
  // launch log and length of each idle stretch
  always @(posedge clk_in) begin
    if (!srst_in && conv_start_out) starts.push_back(conv_chan_out);
    if (!busy_out) begin
      low_cnt <= low_cnt + 1;
    end else if (low_cnt != 0) begin
      pause_len <= low_cnt;
      low_cnt <= 0;
    end
  end
  // ----------------------------------------
  // expectations and bus tasks
  // ----------------------------------------
  function automatic int samples_for(input int ch, input logic [2:0] avg);
    logic diode;
    diode = (ch == 0) || (ch == 7);
    if (avg[2]) return 32;
    if (avg[1]) return 16;
    if (avg[0]) return diode ? 16 : 1;
    return diode ? 128 : 8;
  endfunction
  function automatic logic [7:0] exp_reading(input int ch);
    if ((ch == 0 || ch == 7) && diode_fault_in[ch / 7]) return en1[ch] ? 8'h80 : 8'h00;
    return chan_vals[ch * 8 +: 8];
  endfunction
  function automatic logic [7:0] exp_status1();
    logic [7:0] s;
    s = 8'h00;
    for (int ch = 0; ch < 8; ch++) begin
      if (en1[ch] && (exp_reading(ch) >= hi[ch] || exp_reading(ch) <= lo[ch])) s[ch] = 1'b1;
    end
    return s;
  endfunction
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    reg_addr_in = addr;
    reg_wdata_in = data;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic reg_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
    @(negedge clk_in);
    reg_addr_in = addr;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    check8(reg_rdata_out, exp, what);
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy_out !== lvl && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    check8({7'h00, busy_out}, {7'h00, lvl}, "busy level");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // a shortened pass is near 14k clocks, so 50k clocks leave ample margin
  initial begin
    #1000000;
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int k;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    srst_in = 1'b0;
    reg_chk(`HWM_STATUS1, 8'h00, "status1 reset");
    reg_chk(`HWM_STATUS2, 8'h00, "status2 reset");
    reg_chk(`HWM_SFR, `HWM_SFR_RST, "sfr reset");
    reg_wr(`HWM_STATUS1, 8'hff);
    reg_chk(`HWM_STATUS1, 8'h00, "status1 write");
    reg_wr(`HWM_STATUS2, 8'hff);
    reg_chk(`HWM_STATUS2, 8'h00, "status2 write");
    reg_chk(8'h9a, 8'h00, "unmapped read");
    $display("test reset_regs done");
    for (int ch = 0; ch < 8; ch++) begin
      chan_vals[ch * 8 +: 8] = 8'h10 + {1'b0, 7'($random(seed))};
      lo[ch] = `HWM_LIM_LO_RST;
      hi[ch] = `HWM_LIM_HI_RST;
    end
    hi[0] = 8'h7f;
    hi[2] = chan_vals[23:16];
    lo[3] = chan_vals[31:24];
    hi[4] = 8'h00;
    lo[7] = `HWM_LIM_LO_RST;
    en1 = 8'h6f;
    for (int ch = 0; ch < 8; ch++) begin
      reg_wr(`HWM_LIM_LO_BASE + 8'(ch), lo[ch]);
      reg_wr(`HWM_LIM_HI_BASE + 8'(ch), hi[ch]);
    end
    reg_wr(`HWM_EN1, en1);
    reg_wr(`HWM_GRP_EN, 8'h03);
    reg_wr(`HWM_SFR, 8'h26);
    diode_fault_in = 2'b11;
    reg_wr(`HWM_RLS, 8'h01);
    wait_busy(1'b1, 16);
    wait_busy(1'b0, 30000);
    for (int ch = 0; ch < 8; ch++) reg_chk(`HWM_READ_BASE + 8'(ch), exp_reading(ch), "reading");
    check8({6'h00, fan_full_out}, 8'h01, "fan zones");
    check8({7'h00, irq_n_out}, 8'h00, "irq low");
    reg_chk(`HWM_STATUS1, exp_status1(), "status1 set");
    reg_chk(`HWM_STATUS1, exp_status1(), "status1 kept");
    diode_fault_in = 2'b00;
    reg_chk(`HWM_STATUS2, {6'h00, en1[7], en1[0]}, "status2 set");
    reg_chk(`HWM_STATUS2, 8'h00, "status2 cleared");
    $display("test readings done");
    wait_busy(1'b1, 8000);
    repeat (2) @(negedge clk_in);
    total_checks++;
    if (pause_len < 3 * DIV || pause_len > 5 * DIV) begin
      num_errors++;
      $display("ERROR %0t pause length %0d", $time, pause_len);
    end
    k = 0;
    for (int ch = 0; ch < 9; ch++) begin
      for (int s = 0; s < (ch == 8 ? 1 : samples_for(ch, 3'b001)); s++) begin
        check8({5'h00, starts[k]}, 8'(ch % 8), "launch order");
        k++;
      end
    end
    $display("test order_and_pause done");
    reg_wr(`HWM_SFR, 8'h22);
    repeat (2) @(negedge clk_in);
    check8({7'h00, irq_n_out}, 8'h01, "irq masked");
    reg_wr(`HWM_SFR, 8'h26);
    repeat (2) @(negedge clk_in);
    check8({7'h00, irq_n_out}, 8'h00, "irq unmasked");
    reg_wr(`HWM_GRP_EN, 8'h00);
    repeat (2) @(negedge clk_in);
    check8({7'h00, irq_n_out}, 8'h01, "irq groups off");
    reg_wr(`HWM_RLS, 8'h00);
    $display("test irq_enables done");
    close_out();
  end
endmodule
